//--- rtl/clock_management.sv
// Clock management control: trim stepping, spread, sync source and pin drive.
// Assumes fuse inputs are stable while sys_rst is high and a register master
// that keeps the strobe rules of the plain register port.

// How it works
// - Control logic and timers all run from the single 20 MHz core clock.
// - High-frequency clock nominal 20 MHz, trimmed about plus or minus 20 percent.
// - Four-bit trim selects 1 MHz steps; only nine codes are meaningful.
// - Multi-step changes walk every step, 5.2 us apart.
// - Arriving at the programmed step sets tuning done and interrupt unless masked.
// - Internal source: switching clock is high-frequency clock divided by 8.
// - Trim powers up from its fused copy.
// - Trim stepping frozen while spread or external clock is active.
// - Spread enable bit switches modulation; power-up from fuse.
// - Spread width bit picks 5 or 10 percent; power-up from fuse.
// - Spread modulates at 24 kHz on the internal path.
// - Sync mode 1 disables spread regardless of its enable.
// - Sync mode 0: PLL off, internal only; 1: PLL on, either source.
// - Band bit picks accepted input range; outside it is invalid.
// - Missing or invalid clock: fall back internal, set loss flag, interrupt.
// - Live loss status is 1 while input bad, 0 when valid.
// - Return to external only after flag cleared and input valid.
// - Sync mode 0 with drive enable toggles the pin, without it drives low; mode 1 releases the pin.
module clock_management (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] fused_hf_clock_trim,
  input wire logic fused_spread_enable,
  input wire logic fused_spread_width_select,
  input wire logic fused_input_band_select,
  input wire logic fused_clock_drive_enable,
  input wire logic fused_sync_mode,
  input wire logic sync_pin_in,
  output logic sync_pin_out,
  output logic sync_pin_oe_n,
  output logic [3:0] hf_step_code,
  output logic switching_clk,
  output logic pll_enable,
  output logic ext_clock_selected,
  output logic spread_active,
  output logic spread_wide,
  output logic [8:0] spread_level,
  output logic irq_out_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic {SRC_INTERNAL, SRC_EXTERNAL} source_t;

  localparam logic [6:0] STEP_LAST = 7'(clock_mgmt_pkg::STEP_CYCLES - 1);
  localparam logic [2:0] DIV_LAST = 3'(clock_mgmt_pkg::SW_DIVIDE - 1);
  localparam logic [2:0] DIV_HALF = 3'(clock_mgmt_pkg::SW_DIVIDE / 2);

  ext_clock_if mon ();

  source_t src;
  logic sync_mode;
  logic [3:0] hf_clock_trim;
  logic spread_enable;
  logic spread_width_select;
  logic input_band_select;
  logic clock_drive_enable;
  logic [1:0] flags;
  logic [1:0] mask;
  logic [3:0] cur_step;
  logic [6:0] step_timer;
  logic [2:0] div_cnt;
  logic pin_meta;
  logic pin_sync;
  logic [3:0] target_step;
  logic [3:0] next_step;
  logic step_freeze;
  logic step_due;
  logic step_arrive;
  logic spread_run;
  logic loss_event;
  logic wr_trim;
  logic wr_cfg;
  logic wr_flags;
  logic wr_mask;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic [1:0] next_flags;
  logic [7:0] status;
  logic [7:0] read_mux;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  // Writes land in the cycle of the strobe; no wait states
  assign wr_trim = reg_wr && (reg_addr == clock_mgmt_pkg::REG_TRIM);
  assign wr_cfg = reg_wr && (reg_addr == clock_mgmt_pkg::REG_CFG);
  assign wr_flags = reg_wr && (reg_addr == clock_mgmt_pkg::REG_FLAGS);
  assign wr_mask = reg_wr && (reg_addr == clock_mgmt_pkg::REG_MASK);

  // Trim target; fuse copy at reset, unused codes dropped
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hf_clock_trim <= fused_hf_clock_trim;
    end else if (wr_trim && clock_mgmt_pkg::trim_valid(reg_wdata[3:0])) begin
      hf_clock_trim <= reg_wdata[3:0];
    end
  end

  // Configuration bits, each powered up from its fused copy
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      spread_enable <= fused_spread_enable;
      spread_width_select <= fused_spread_width_select;
      input_band_select <= fused_input_band_select;
      clock_drive_enable <= fused_clock_drive_enable;
      sync_mode <= fused_sync_mode; // Fused only; no runtime write path
    end else if (wr_cfg) begin
      spread_enable <= reg_wdata[clock_mgmt_pkg::CFG_SPREAD_EN_BIT];
      spread_width_select <= reg_wdata[clock_mgmt_pkg::CFG_SPREAD_WIDE_BIT];
      input_band_select <= reg_wdata[clock_mgmt_pkg::CFG_BAND_BIT];
      clock_drive_enable <= reg_wdata[clock_mgmt_pkg::CFG_DRIVE_BIT];
    end
  end

  // Interrupt mask; a set bit keeps that flag off the interrupt line
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mask <= clock_mgmt_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Trim stepping
  // ----------------------------------------------------------------
  // Steps are walked one at a time so the regulators never see a jump
  always_comb begin
    target_step = clock_mgmt_pkg::trim_to_step(hf_clock_trim);
    step_freeze = spread_run || (src == SRC_EXTERNAL);
    step_due = !step_freeze && (cur_step != target_step) && (step_timer == STEP_LAST);
    next_step = (cur_step < target_step) ? cur_step + 4'h1 : cur_step - 4'h1;
    step_arrive = step_due && (next_step == target_step);
  end

  // Step timer and current step; timer restarts whenever the walk pauses
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cur_step <= clock_mgmt_pkg::trim_to_step(fused_hf_clock_trim);
      step_timer <= 7'h00;
    end else if (step_freeze || cur_step == target_step) begin
      step_timer <= 7'h00;
    end else if (step_due) begin
      cur_step <= next_step;
      step_timer <= 7'h00;
    end else begin
      step_timer <= step_timer + 7'h01;
    end
  end

  // Code presented to the analog oscillator
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hf_step_code <= fused_hf_clock_trim;
    end else begin
      hf_step_code <= clock_mgmt_pkg::step_to_trim(cur_step);
    end
  end

  // ----------------------------------------------------------------
  // Spread spectrum
  // ----------------------------------------------------------------
  // Sync mode overrides the enable bit outright
  assign spread_run = spread_enable && !sync_mode;

  // Spread status outputs for the analog side
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      spread_active <= 1'b0;
      spread_wide <= 1'b0;
    end else begin
      spread_active <= spread_run;
      spread_wide <= spread_width_select;
    end
  end

  spread_modulator u_spread (
    .core_clk (core_clk),
    .sys_rst (sys_rst),
    .run (spread_run),
    .level (spread_level)
  );

  // ----------------------------------------------------------------
  // External clock input
  // ----------------------------------------------------------------
  // Two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= sync_pin_in;
      pin_sync <= pin_meta;
    end
  end

  assign mon.pin_level = pin_sync;
  assign mon.band_select = input_band_select;

  clock_band_checker u_checker (
    .core_clk (core_clk),
    .sys_rst (sys_rst),
    .mon (mon)
  );

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  // Loss only counts while actually following the pin
  assign loss_event = (src == SRC_EXTERNAL) && !mon.clock_valid;

  // Source state; sync mode 0 pins it to the internal clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      src <= SRC_INTERNAL;
      ext_clock_selected <= 1'b0;
    end else begin
      unique case (src)
        SRC_INTERNAL: begin
          // Flag must be cleared first so a flapping pin cannot bounce us
          if (sync_mode && mon.clock_valid && !flags[clock_mgmt_pkg::FLAG_LOSS_BIT]) begin
            src <= SRC_EXTERNAL;
            ext_clock_selected <= 1'b1;
          end
        end
        SRC_EXTERNAL: begin
          if (loss_event || !sync_mode) begin
            src <= SRC_INTERNAL;
            ext_clock_selected <= 1'b0;
          end
        end
      endcase
    end
  end

  // PLL runs whenever sync mode is fused on
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pll_enable <= 1'b0;
    end else begin
      pll_enable <= sync_mode;
    end
  end

  // ----------------------------------------------------------------
  // Switching clock and pin drive
  // ----------------------------------------------------------------
  // Divide by 8; while external the output follows the pin instead
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_cnt <= 3'h0;
      switching_clk <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == DIV_LAST) ? 3'h0 : div_cnt + 3'h1;
      if (src == SRC_EXTERNAL) begin
        switching_clk <= pin_sync;
      end else begin
        switching_clk <= (div_cnt >= DIV_HALF);
      end
    end
  end

  // Pin drive: toggle or hold low in mode 0, released as input in mode 1
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_pin_out <= 1'b0;
      sync_pin_oe_n <= 1'b1;
    end else if (!sync_mode) begin
      sync_pin_oe_n <= 1'b0;
      sync_pin_out <= clock_drive_enable && (div_cnt >= DIV_HALF);
    end else begin
      sync_pin_oe_n <= 1'b1; // Board keeps it low until a source starts
      sync_pin_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  // Write-one-to-clear; a set in the same cycle as its clear wins
  always_comb begin
    flag_set = 2'h0;
    flag_set[clock_mgmt_pkg::FLAG_TUNING_BIT] = step_arrive;
    flag_set[clock_mgmt_pkg::FLAG_LOSS_BIT] = loss_event && sync_mode;
    flag_clr = wr_flags ? reg_wdata[1:0] : 2'h0;
    next_flags = (flags & ~flag_clr) | flag_set;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags <= clock_mgmt_pkg::FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // Active-low interrupt from any unmasked flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~|(flags & ~mask);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Live status; loss bit follows the checker, not the sticky flag
  always_comb begin
    status = 8'h00;
    status[clock_mgmt_pkg::STAT_LIVE_BIT] = !mon.clock_valid;
    status[clock_mgmt_pkg::STAT_EXT_BIT] = (src == SRC_EXTERNAL);
    status[clock_mgmt_pkg::STAT_PLL_BIT] = sync_mode;
    status[clock_mgmt_pkg::STAT_BUSY_BIT] = (cur_step != target_step);
    status[clock_mgmt_pkg::STAT_STEP_LSB +: 4] = clock_mgmt_pkg::step_to_trim(cur_step);
  end

  always_comb begin
    unique case (reg_addr)
      clock_mgmt_pkg::REG_TRIM: read_mux = {4'h0, hf_clock_trim};
      clock_mgmt_pkg::REG_CFG: read_mux = {4'h0, clock_drive_enable, input_band_select,
                                           spread_width_select, spread_enable};
      clock_mgmt_pkg::REG_FLAGS: read_mux = {6'h00, flags};
      clock_mgmt_pkg::REG_MASK: read_mux = {6'h00, mask};
      clock_mgmt_pkg::REG_STATUS: read_mux = status;
      default: read_mux = 8'h00; // Unmapped offsets read zero
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? read_mux : 8'h00;
    end
  end

endmodule

//--- rtl/clock_mgmt_pkg.sv
// Shared constants, register map and trim code helpers for the clock management block.
// Assumes a single 20 MHz core clock and an 8-bit register port.
package clock_mgmt_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_TIME_NS = 5200;
  // Least time between trim steps, rounded up
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPREAD_MOD_HZ = 24_000;
  localparam int SPREAD_MOD_CYCLES = CLK_HZ / SPREAD_MOD_HZ;
  localparam int SW_DIVIDE = 8;

  // ----------------------------------------------------------------
  // Accepted input bands, as periods in core cycles
  // ----------------------------------------------------------------
  localparam int BAND0_MIN_KHZ = 2000;
  localparam int BAND0_MAX_KHZ = 3000;
  localparam int BAND1_MIN_KHZ = 333;
  localparam int BAND1_MAX_KHZ = 500;
  localparam int PER_W = 7;
  localparam logic [6:0] BAND0_MIN_CYC = 7'(CLK_HZ / (BAND0_MAX_KHZ * 1000));
  localparam logic [6:0] BAND0_MAX_CYC = 7'(CLK_HZ / (BAND0_MIN_KHZ * 1000));
  localparam logic [6:0] BAND1_MIN_CYC = 7'(CLK_HZ / (BAND1_MAX_KHZ * 1000));
  localparam logic [6:0] BAND1_MAX_CYC = 7'(CLK_HZ / (BAND1_MIN_KHZ * 1000));

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_TRIM = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_FLAGS = 4'h2;
  localparam logic [3:0] REG_MASK = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CFG_SPREAD_EN_BIT = 0;
  localparam int CFG_SPREAD_WIDE_BIT = 1;
  localparam int CFG_BAND_BIT = 2;
  localparam int CFG_DRIVE_BIT = 3;
  localparam int FLAG_TUNING_BIT = 0;
  localparam int FLAG_LOSS_BIT = 1;
  localparam int STAT_LIVE_BIT = 0;
  localparam int STAT_EXT_BIT = 1;
  localparam int STAT_PLL_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_STEP_LSB = 4;
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Trim codes: step index 0..8 stands for 16..24 MHz
  // ----------------------------------------------------------------
  localparam logic [3:0] TRIM_HIGH_LAST = 4'h4;
  localparam logic [3:0] TRIM_LOW_FIRST = 4'h9;
  localparam logic [3:0] TRIM_LOW_LAST = 4'hc;
  localparam logic [3:0] STEP_OF_TRIM0 = 4'h4;

  function automatic logic trim_valid(input logic [3:0] code);
    return (code <= TRIM_HIGH_LAST) || (code >= TRIM_LOW_FIRST && code <= TRIM_LOW_LAST);
  endfunction

  function automatic logic [3:0] trim_to_step(input logic [3:0] code);
    return (code <= TRIM_HIGH_LAST) ? code + STEP_OF_TRIM0 : code - TRIM_LOW_FIRST;
  endfunction

  function automatic logic [3:0] step_to_trim(input logic [3:0] step);
    return (step >= STEP_OF_TRIM0) ? step - STEP_OF_TRIM0 : step + TRIM_LOW_FIRST;
  endfunction

endpackage

//--- rtl/ext_clock_if.sv
// Carries the synchronised clock pin and band choice to the band checker.
// Assumes both ends run on core_clk.
interface ext_clock_if;
  logic pin_level;
  logic band_select;
  logic clock_valid;
  modport owner (output pin_level, output band_select, input clock_valid);
  modport monitor (input pin_level, input band_select, output clock_valid);
endinterface

//--- rtl/clock_band_checker.sv
// Measures the period of the external clock and flags it valid inside the band.
// Assumes pin_level is already synchronised to core_clk.
module clock_band_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  ext_clock_if.monitor mon
);

  logic [6:0] period_cnt;
  logic [6:0] lo_cyc;
  logic [6:0] hi_cyc;
  logic [6:0] measured;
  logic prev_level;
  logic band_q;

  // Band limits and the period ending at this edge
  always_comb begin
    lo_cyc = mon.band_select ? clock_mgmt_pkg::BAND1_MIN_CYC : clock_mgmt_pkg::BAND0_MIN_CYC;
    hi_cyc = mon.band_select ? clock_mgmt_pkg::BAND1_MAX_CYC : clock_mgmt_pkg::BAND0_MAX_CYC;
    measured = period_cnt + 7'h01;
  end

  // Period count between rising edges; a stalled pin times out as invalid
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      period_cnt <= 7'h00;
      prev_level <= 1'b0;
      band_q <= 1'b0;
      mon.clock_valid <= 1'b0;
    end else begin
      prev_level <= mon.pin_level;
      band_q <= mon.band_select;
      if (band_q != mon.band_select) begin
        period_cnt <= 7'h00;
        mon.clock_valid <= 1'b0;
      end else if (mon.pin_level && !prev_level) begin
        period_cnt <= 7'h00;
        mon.clock_valid <= (measured >= lo_cyc) && (measured <= hi_cyc);
      end else if (period_cnt < hi_cyc) begin
        period_cnt <= measured;
      end else begin
        mon.clock_valid <= 1'b0; // Missing edge: too slow or absent
      end
    end
  end

endmodule

//--- rtl/spread_modulator.sv
// Triangle modulation profile for spread-spectrum on the internal clock.
// Assumes the analog oscillator scales the level by the selected width.
module spread_modulator (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  output logic [8:0] level
);

  localparam logic [9:0] LAST = 10'(clock_mgmt_pkg::SPREAD_MOD_CYCLES - 1);
  localparam logic [9:0] HALF = 10'(clock_mgmt_pkg::SPREAD_MOD_CYCLES / 2);

  logic [9:0] phase;

  // One triangle per modulation period; parked at level zero when idle
  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      phase <= 10'h000;
      level <= 9'h000;
    end else begin
      phase <= (phase == LAST) ? 10'h000 : phase + 10'h001;
      level <= (phase < HALF) ? phase[8:0] : 9'(LAST - phase);
    end
  end

endmodule

//--- tb/ext_clock_source.sv
// Model of an external clock source on the shared clock pin.
// Assumes the bench sets run and half_ns; the pin rests low when stopped.
module ext_clock_source (
  input wire logic run,
  input wire logic [31:0] half_ns,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Even duty; idle low as the board pull-down would leave it
  initial begin
    pin = 1'b0;
    forever begin
      if (run) begin
        #(half_ns) pin = 1'b1;
        #(half_ns) pin = 1'b0;
      end else begin
        pin = 1'b0;
        #50;
      end
    end
  end
endmodule

//--- tb/clock_management_properties.sv
// Port-level checks for the clock management top, attached by bind.
// Assumes one core_clk domain and synchronous active-high sys_rst.
module clock_management_properties (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] hf_step_code,
  input wire logic switching_clk,
  input wire logic sync_pin_oe_n,
  input wire logic pll_enable,
  input wire logic ext_clock_selected,
  input wire logic spread_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Step tracking
  // ----------------------------------------------------------------
  // Gap saturates so a long idle spell never wraps into a short one
  logic [3:0] prev_code;
  logic [7:0] gap;
  always_ff @(posedge core_clk) begin
    prev_code <= hf_step_code;
    if (sys_rst) begin
      gap <= 8'hff;
    end else if (hf_step_code != prev_code) begin
      gap <= 8'h00;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end
  // Frequency in MHz of a trim code
  function automatic int mhz(input logic [3:0] c);
    return (c <= 4'h4) ? 20 + int'(c) : int'(c) + 7;
  endfunction
  sequence hi4(logic s);
    s [*4];
  endsequence
  sequence lo4(logic s);
    !s [*4];
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  code_valid_a: assert property ((hf_step_code <= 4'h4) ||
    (hf_step_code >= 4'h9 && hf_step_code <= 4'hc)) else $error("unused trim code applied");
  step_gap_a: assert property (hf_step_code != prev_code |->
    gap >= 8'(clock_mgmt_pkg::STEP_CYCLES - 1))
    else $error("trim steps too close");
  step_single_a: assert property (hf_step_code != prev_code |->
    (mhz(hf_step_code) == mhz(prev_code) + 1) || (mhz(hf_step_code) + 1 == mhz(prev_code)))
    else $error("trim skipped a step");
  sw_divide_a: assert property ($rose(switching_clk) && !pll_enable |->
    hi4(switching_clk) ##1 lo4(switching_clk)) else $error("switching clock not divide by 8");
  // Skips the first edge after reset, where both outputs still hold reset values
  pin_drive_a: assert property (!pll_enable && !$past(sys_rst) |-> !sync_pin_oe_n)
    else $error("pin not driven in internal mode");
  pin_release_a: assert property (pll_enable |-> sync_pin_oe_n)
    else $error("pin driven in sync mode");
  sync_spread_a: assert property (pll_enable |-> !spread_active)
    else $error("spread running in sync mode");
  ext_needs_pll_a: assert property (ext_clock_selected |-> pll_enable)
    else $error("external clock without sync mode");
endmodule

bind clock_management clock_management_properties u_clock_management_properties (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .hf_step_code(hf_step_code),
  .switching_clk(switching_clk),
  .sync_pin_oe_n(sync_pin_oe_n),
  .pll_enable(pll_enable),
  .ext_clock_selected(ext_clock_selected),
  .spread_active(spread_active)
);

//--- tb/clock_management_bench.sv
// Self-checking bench for the clock management block.
// Assumes the plain register port and a 20 MHz core clock.
module clock_management_bench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic f_mode = 1'b0;
  logic f_spread = 1'b0;
  logic run = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] code;
  logic [8:0] lvl;
  logic pin, pin_out, oe_n, sw_clk, pll_en, ext_sel, sp_act, sp_wide, irq_n;
  int half_ns = 200;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int rises = 0;
  int sw_rises = 0;
  int t0;
  logic [3:0] down[6] = '{4'h1, 4'h0, 4'hc, 4'hb, 4'ha, 4'h9};
  logic [3:0] up[3] = '{4'hb, 4'hc, 4'h0};
  clock_management u_clock_management (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fused_hf_clock_trim(4'h2), .fused_spread_enable(f_spread),
    .fused_spread_width_select(1'b1), .fused_input_band_select(1'b0),
    .fused_clock_drive_enable(1'b1), .fused_sync_mode(f_mode), .sync_pin_in(pin),
    .sync_pin_out(pin_out), .sync_pin_oe_n(oe_n), .hf_step_code(code),
    .switching_clk(sw_clk), .pll_enable(pll_en), .ext_clock_selected(ext_sel),
    .spread_active(sp_act), .spread_wide(sp_wide), .spread_level(lvl), .irq_out_n(irq_n));
  ext_clock_source u_ext_clock_source (.run(run), .half_ns(half_ns), .pin(pin));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge pin_out) rises++;
  always @(posedge sw_clk) sw_rises++;
  // Watchdog; the whole sequence needs about 3200 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata & m, e)
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    tick(1);
    for (int i = 0; i < lim && s !== v; i++) tick(1);
    `CHK(s, v)
  endtask
  // Next applied code within one step time plus margin
  task automatic step_to(input logic [3:0] e);
    logic [3:0] p;
    p = code;
    for (int i = 0; i < 110 && code === p; i++) tick(1);
    `CHK(code, e)
  endtask
  task automatic do_reset(input logic m, input logic sp);
    @(posedge core_clk);
    f_mode <= m;
    f_spread <= sp;
    sys_rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(2);
  endtask
  initial begin
    do_reset(1'b0, 1'b0);
    `CHK(code, 4'h2)
    `CHK(sp_wide, 1'b1)
    `CHK({pll_en, oe_n, sp_act}, 3'b000)
    rd(4'h1, 8'h0f, 8'h0a);
    rises = 0;
    sw_rises = 0;
    tick(80);
    `CHK(rises, 10)
    `CHK(sw_rises, 10)
    wr(4'h1, 8'h02);
    tick(2);
    rises = 0;
    tick(40);
    `CHK(rises, 0)
    `CHK(pin_out, 1'b0)
    // Unused code is ignored
    wr(4'h0, 8'h07);
    rd(4'h0, 8'h0f, 8'h02);
    // Six-step walk down, flag only at the end
    wr(4'h0, 8'h09);
    foreach (down[i]) begin
      `CHK(irq_n, 1'b1)
      step_to(down[i]);
    end
    tick(3);
    `CHK(irq_n, 1'b0)
    rd(4'h2, 8'h03, 8'h01);
    wr(4'h2, 8'h01);
    tick(2);
    `CHK(irq_n, 1'b1)
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h0a);
    step_to(4'ha);
    tick(3);
    `CHK(irq_n, 1'b1)
    rd(4'h2, 8'h03, 8'h01);
    // Spread on: modulation period and frozen trim
    wr(4'h1, 8'h01);
    tick(2);
    `CHK(sp_act, 1'b1)
    `CHK(sp_wide, 1'b0)
    for (int i = 0; i < 900 && lvl !== 9'd416; i++) tick(1);
    t0 = cycles;
    tick(1);
    for (int i = 0; i < 900 && lvl !== 9'd416; i++) tick(1);
    `CHK(cycles - t0, 20_000_000 / 24_000)
    wr(4'h0, 8'h00);
    tick(300);
    `CHK(code, 4'ha)
    wr(4'h1, 8'h00);
    tick(2);
    `CHK(sp_act, 1'b0)
    foreach (up[i]) step_to(up[i]);
    // Sync mode: follow, lose, recover
    do_reset(1'b1, 1'b1);
    `CHK({pll_en, oe_n, sp_act}, 3'b110)
    run = 1'b1;
    wait_for(ext_sel, 1'b1, 100);
    rd(4'h4, 8'h07, 8'h06);
    run = 1'b0;
    wait_for(ext_sel, 1'b0, 100);
    tick(2);
    `CHK(irq_n, 1'b0)
    rd(4'h4, 8'h01, 8'h01);
    rd(4'h2, 8'h02, 8'h02);
    run = 1'b1;
    tick(100);
    rd(4'h4, 8'h03, 8'h00);
    wr(4'h2, 8'h02);
    wait_for(ext_sel, 1'b1, 20);
    half_ns = 1200;
    wait_for(ext_sel, 1'b0, 150);
    wr(4'h1, 8'h05);
    tick(200);
    rd(4'h4, 8'h01, 8'h00);
    wr(4'h2, 8'h02);
    wait_for(ext_sel, 1'b1, 20);
    wrap_up();
  end
endmodule
